// [adcsq_regs.svh]
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH
// register byte offsets
`define ADCSQ_OFF_CTRL0 8'h00
`define ADCSQ_OFF_CTRL2 8'h04
`define ADCSQ_OFF_RESH 8'h08
`define ADCSQ_OFF_RESL 8'h0c
`define ADCSQ_OFF_STAT 8'h10
`define ADCSQ_OFF_PORT 8'h14
`define ADCSQ_OFF_AMASK 8'h18
`define ADCSQ_OFF_CMODE 8'h1c
// field positions
`define ADCSQ_B_ON 0
`define ADCSQ_B_GO 1
`define ADCSQ_F_CHAN 5:2
`define ADCSQ_B_CAL 7
`define ADCSQ_B_JUST 7
`define ADCSQ_F_ACQ 5:3
`define ADCSQ_F_CLK 2:0
`define ADCSQ_B_DONE 0
// reset values and codes
`define ADCSQ_RST_AMASK 13'h1fff
`define ADCSQ_TRIG_MODE 4'hb
// timing
`define ADCSQ_CONV_TADS 5'h0b
`define ADCSQ_RECOV_TADS 5'h02
`define ADCSQ_CLK_NS 100
`define ADCSQ_TCY_NS 400
`define ADCSQ_TCY_CYC ((`ADCSQ_TCY_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`endif

// [adcsq_pkg.sv]
package adcsq_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DLY = 5'h02,
        ST_ACQ = 5'h04,
        ST_CONV = 5'h08,
        ST_RECOV = 5'h10
    } adcsq_state_e;
    typedef logic [9:0] adcsq_res_t;
endpackage

// [adcsq_top.sv]
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`include "adcsq_regs.svh"
// Overview of operation
// R1: zero acquisition: start ends sampling, converts
// R2: software times acquisition when field zero
// R3: acquisition field bits 5:3, resets zero
// R4: nonzero field: sample selected periods, convert
// R5: code 010 gives four bit periods
// R6: done clears start, sets flag, resamples
// R7: no status separates acquisition from conversion
// R8: conversion lasts exactly eleven bit periods
// R9: clock select decodes divider or RC
// R10: zero acquisition delays start one instruction
// R11: clearing start aborts, result kept
// R12: two bit periods wait, then resample
// R13: do not start while turning on
// R14: compare trigger sets start, clears timer
// R15: disabled converter ignores trigger, timer cleared
// R16: calibration request makes offset dummy conversion
// R17: calibrate after reset and big changes
// R18: analog pins read zero from port
// R19: acquisition field decodes to bit periods
// R20: start bit one while busy
// R21: RC clock adds one instruction delay
// R22: justify bit selects right or left
// R23: disable or reset aborts to idle
module adcsq_top (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic I_RC_CLK,
    input wire logic I_SPECIAL_TRIG,
    input wire adcsq_pkg::adcsq_res_t I_CORE_RESULT,
    input wire logic [12:0] I_PORT_PIN,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic O_SAMPLE,
    output logic O_CONVERTING,
    output logic O_CONV_START,
    output logic O_CAL_MODE,
    output logic [3:0] O_CHANNEL,
    output logic O_TIMER_CLR,
    output logic O_DONE_FLAG
);
    import adcsq_pkg::*;

    logic on_ff, go_ff, cal_req_ff, cal_run_ff, just_ff, irq_ff;
    logic [3:0] chan_ff, cmode_ff;
    logic [2:0] acq_ff, clks_ff, dly_ff;
    logic [7:0] resh_ff, resl_ff, wa_ff;
    adcsq_res_t offs_ff, corr;
    logic [12:0] amask_ff, pin_s1_ff, pin_s2_ff;
    logic rc_s1_ff, rc_s2_ff, rc_s3_ff;
    adcsq_state_e st_ff;
    logic [4:0] tad_ff, acq_n;
    logic [5:0] pre_ff;
    logic wr_ff, sample_ff, cstart_ff, tclr_ff;
    logic [31:0] rdata;
    logic rc_sel, pre_end, tick, wr, sw_ctl, done, trig_go;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic [6:0] div_of(input logic [2:0] s);
        case (s) // R9
            3'h0: return 7'h02;
            3'h4: return 7'h04;
            3'h1: return 7'h08;
            3'h5: return 7'h10;
            3'h2: return 7'h20;
            3'h6: return 7'h40;
            default: return 7'h02;
        endcase
    endfunction

    function automatic logic [4:0] acq_of(input logic [2:0] s);
        case (s) // R19
            3'h0: return 5'h00;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h06;
            3'h4: return 5'h08;
            3'h5: return 5'h0c;
            3'h6: return 5'h10;
            default: return 5'h14;
        endcase
    endfunction

    //----------------------------------------
    // conversion clock
    //----------------------------------------
    assign rc_sel = clks_ff[1:0] == 2'h3; // R9
    assign pre_end = pre_ff == 6'(div_of(clks_ff) - 7'h01);
    assign tick = I_CE & (rc_sel ? (rc_s2_ff & ~rc_s3_ff) : pre_end);
    assign acq_n = acq_of(acq_ff);
    assign wr = I_CE & wr_ff;
    assign sw_ctl = wr & hit(wa_ff, `ADCSQ_OFF_CTRL0);
    assign done = tick & on_ff & go_ff & (st_ff == ST_CONV) & (tad_ff == `ADCSQ_CONV_TADS - 5'h01);
    assign trig_go = I_CE & I_SPECIAL_TRIG & on_ff & (cmode_ff == `ADCSQ_TRIG_MODE);
    assign corr = (I_CORE_RESULT > offs_ff) ? I_CORE_RESULT - offs_ff : 10'h000;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rc_s1_ff <= 1'b0;
            rc_s2_ff <= 1'b0;
            rc_s3_ff <= 1'b0;
            pin_s1_ff <= 13'h0000;
            pin_s2_ff <= 13'h0000;
            pre_ff <= 6'h00;
        end else if (I_CE) begin
            rc_s1_ff <= I_RC_CLK;
            rc_s2_ff <= rc_s1_ff;
            rc_s3_ff <= rc_s2_ff;
            pin_s1_ff <= I_PORT_PIN;
            pin_s2_ff <= pin_s1_ff;
            // divider restarts when a run begins, so the first bit period is a whole one
            pre_ff <= (rc_sel | pre_end | (st_ff == ST_IDLE) | (st_ff == ST_DLY)) ? 6'h00 : pre_ff + 6'h01; // R8
        end
    end

    //----------------------------------------
    // bus slave
    //----------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(I_HADDR[7:0], `ADCSQ_OFF_CTRL0))
            rdata = {24'h0, cal_req_ff, 1'b0, chan_ff, go_ff, on_ff}; // R7 R20
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_CTRL2))
            rdata = {24'h0, just_ff, 1'b0, acq_ff, clks_ff};
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_RESH))
            rdata = {24'h0, resh_ff};
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_RESL))
            rdata = {24'h0, resl_ff};
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_STAT))
            rdata = {31'h0, irq_ff};
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_PORT))
            rdata = {19'h0, pin_s2_ff & ~amask_ff}; // R18
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_AMASK))
            rdata = {19'h0, amask_ff};
        else if (hit(I_HADDR[7:0], `ADCSQ_OFF_CMODE))
            rdata = {28'h0, cmode_ff};
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else if (I_CE) begin
            wr_ff <= I_HSEL & I_HTRANS[1] & I_HWRITE & I_HREADY;
            wa_ff <= I_HADDR[7:0];
            if (I_HSEL & I_HTRANS[1] & ~I_HWRITE & I_HREADY)
                O_HRDATA <= rdata;
        end
    end

    //----------------------------------------
    // control registers
    //----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            on_ff <= 1'b0;
            chan_ff <= 4'h0;
            cal_req_ff <= 1'b0;
            acq_ff <= 3'h0; // R3
            clks_ff <= 3'h0;
            just_ff <= 1'b0;
            amask_ff <= `ADCSQ_RST_AMASK;
            cmode_ff <= 4'h0;
        end else if (I_CE) begin
            if (done & cal_run_ff)
                cal_req_ff <= 1'b0; // R16
            if (sw_ctl) begin
                on_ff <= I_HWDATA[`ADCSQ_B_ON];
                chan_ff <= I_HWDATA[`ADCSQ_F_CHAN];
                cal_req_ff <= I_HWDATA[`ADCSQ_B_CAL];
            end
            if (wr & hit(wa_ff, `ADCSQ_OFF_CTRL2)) begin
                just_ff <= I_HWDATA[`ADCSQ_B_JUST];
                acq_ff <= I_HWDATA[`ADCSQ_F_ACQ]; // R3
                clks_ff <= I_HWDATA[`ADCSQ_F_CLK];
            end
            if (wr & hit(wa_ff, `ADCSQ_OFF_AMASK))
                amask_ff <= I_HWDATA[12:0];
            if (wr & hit(wa_ff, `ADCSQ_OFF_CMODE))
                cmode_ff <= I_HWDATA[3:0];
        end
    end

    // start flag: the trigger set wins over the done clear and a software write; reset and disable keep it clear
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            go_ff <= 1'b0; // R23
        end else if (I_CE) begin
            if (~on_ff | done)
                go_ff <= 1'b0; // R6 R23
            if (sw_ctl)
                go_ff <= I_HWDATA[`ADCSQ_B_GO] & I_HWDATA[`ADCSQ_B_ON]; // R11 R20
            if (trig_go)
                go_ff <= 1'b1; // R14 R15
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            irq_ff <= 1'b0;
            tclr_ff <= 1'b0;
        end else if (I_CE) begin
            if (wr & hit(wa_ff, `ADCSQ_OFF_STAT) & I_HWDATA[`ADCSQ_B_DONE])
                irq_ff <= 1'b0;
            if (done)
                irq_ff <= 1'b1; // R6
            tclr_ff <= I_SPECIAL_TRIG & (cmode_ff == `ADCSQ_TRIG_MODE); // R14 R15
        end
    end

    // result pair: a completed conversion outside calibration wins over a software write
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            resh_ff <= 8'h00;
            resl_ff <= 8'h00;
            offs_ff <= 10'h000;
        end else if (I_CE) begin
            if (wr & hit(wa_ff, `ADCSQ_OFF_RESH))
                resh_ff <= I_HWDATA[7:0];
            if (wr & hit(wa_ff, `ADCSQ_OFF_RESL))
                resl_ff <= I_HWDATA[7:0];
            if (done & cal_run_ff) begin
                offs_ff <= I_CORE_RESULT; // R16
            end else if (done & just_ff) begin
                resh_ff <= {6'h00, corr[9:8]}; // R22
                resl_ff <= corr[7:0];
            end else if (done) begin
                resh_ff <= corr[9:2]; // R22
                resl_ff <= {corr[1:0], 6'h00};
            end
        end
    end

    //----------------------------------------
    // sequencer
    //----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            st_ff <= ST_IDLE; // R23
            tad_ff <= 5'h00;
            dly_ff <= 3'h0;
            cal_run_ff <= 1'b0;
            cstart_ff <= 1'b0;
            sample_ff <= 1'b0;
        end else if (I_CE) begin
            cstart_ff <= 1'b0;
            sample_ff <= on_ff & ((st_ff == ST_IDLE & ~go_ff) | st_ff == ST_ACQ
                | (st_ff == ST_DLY & acq_ff != 3'h0)); // R1 R4 R6
            if (~on_ff) begin
                st_ff <= ST_IDLE; // R23
                cal_run_ff <= 1'b0;
            end else begin
                case (st_ff)
                    ST_IDLE: begin
                        if (go_ff) begin
                            cal_run_ff <= cal_req_ff; // R16
                            tad_ff <= 5'h00;
                            dly_ff <= 3'h0;
                            st_ff <= (acq_ff == 3'h0 | rc_sel) ? ST_DLY : ST_ACQ; // R1 R10 R21
                        end
                    end
                    ST_DLY: begin
                        if (~go_ff) begin
                            st_ff <= ST_RECOV; // R11
                        end else if (dly_ff == 3'(`ADCSQ_TCY_CYC - 1)) begin
                            st_ff <= (acq_ff == 3'h0) ? ST_CONV : ST_ACQ; // R10 R21
                            cstart_ff <= acq_ff == 3'h0;
                        end else begin
                            dly_ff <= dly_ff + 3'h1;
                        end
                    end
                    ST_ACQ: begin
                        if (~go_ff) begin
                            st_ff <= ST_RECOV;
                            tad_ff <= 5'h00;
                        end else if (tick & (tad_ff + 5'h01 >= acq_n)) begin
                            st_ff <= ST_CONV; // R4 R5
                            tad_ff <= 5'h00;
                            cstart_ff <= 1'b1;
                        end else if (tick) begin
                            tad_ff <= tad_ff + 5'h01;
                        end
                    end
                    ST_CONV: begin
                        if (~go_ff | done) begin
                            st_ff <= ST_RECOV; // R8 R11
                            tad_ff <= 5'h00;
                            cal_run_ff <= 1'b0;
                        end else if (tick) begin
                            tad_ff <= tad_ff + 5'h01; // R8
                        end
                    end
                    ST_RECOV: begin
                        if (tick & (tad_ff == `ADCSQ_RECOV_TADS - 5'h01)) begin
                            st_ff <= ST_IDLE; // R12
                            tad_ff <= 5'h00;
                        end else if (tick) begin
                            tad_ff <= tad_ff + 5'h01;
                        end
                    end
                    default: st_ff <= ST_IDLE;
                endcase
            end
        end
    end

    assign O_SAMPLE = sample_ff;
    assign O_CONVERTING = st_ff[3];
    assign O_CONV_START = cstart_ff;
    assign O_CAL_MODE = cal_run_ff;
    assign O_CHANNEL = chan_ff;
    assign O_TIMER_CLR = tclr_ff;
    assign O_DONE_FLAG = irq_ff;

    //----------------------------------------
    // checks
    //----------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    sequence s_conv_last;
        st_ff == ST_CONV && go_ff && on_ff && tick && tad_ff == 5'h0a;
    endsequence
    sequence s_recov_entry;
        st_ff == ST_RECOV && tad_ff == 5'h00;
    endsequence

    property p_conv_end;
        s_conv_last |=> s_recov_entry ##0 (!go_ff && irq_ff);
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion end wrong"); // R6
    property p_conv_len;
        (st_ff == ST_CONV && go_ff && on_ff && tad_ff < 5'h0a) |=> st_ff == ST_CONV;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion left early"); // R8
    property p_acq4;
        (st_ff == ST_ACQ && acq_ff == 3'h2 && go_ff && on_ff && tick && tad_ff == 5'h03)
            |=> (st_ff == ST_CONV && O_CONV_START);
    endproperty
    a_acq4: assert property (p_acq4) else $error("acquisition of four periods wrong"); // R5
    property p_acq_hold;
        (st_ff == ST_ACQ && go_ff && on_ff && tad_ff + 5'h01 < acq_n) |=> st_ff == ST_ACQ;
    endproperty
    a_acq_hold: assert property (p_acq_hold) else $error("acquisition cut short"); // R4
    property p_zero_acq;
        (st_ff == ST_IDLE && go_ff && on_ff && I_CE && acq_ff == 3'h0)
            |=> (st_ff == ST_DLY && !O_SAMPLE) ##1 st_ff != ST_CONV;
    endproperty
    a_zero_acq: assert property (p_zero_acq) else $error("zero acquisition start wrong"); // R1
    property p_recov;
        (st_ff == ST_RECOV && on_ff && tad_ff == 5'h00) |=> st_ff == ST_RECOV;
    endproperty
    a_recov: assert property (p_recov) else $error("recovery wait too short"); // R12
    property p_abort;
        (st_ff == ST_CONV && !go_ff && on_ff && I_CE && !wr)
            |=> (st_ff == ST_RECOV && $stable(resh_ff) && $stable(resl_ff));
    endproperty
    a_abort: assert property (p_abort) else $error("abort changed result"); // R11
    property p_trig;
        trig_go |=> (go_ff && O_TIMER_CLR);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not start"); // R14
    property p_trig_off;
        (I_CE && I_SPECIAL_TRIG && !on_ff && cmode_ff == 4'hb && !sw_ctl) |=> (!go_ff && O_TIMER_CLR);
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("disabled trigger handling wrong"); // R15
    property p_off;
        (I_CE && !on_ff && !sw_ctl) |=> (st_ff == ST_IDLE && !go_ff);
    endproperty
    a_off: assert property (p_off) else $error("disable did not idle"); // R23
endmodule

// [adcsq_core_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module adcsq_core_model #(
    parameter logic [9:0] CAL_OFF = 10'h025
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_conv_start,
    input wire logic i_converting,
    input wire logic i_cal_mode,
    input wire logic [9:0] i_level,
    output adcsq_pkg::adcsq_res_t o_result
);
    import adcsq_pkg::*;
    logic conv_q_ff;
    always_ff @(posedge i_clk) begin
        conv_q_ff <= i_converting;
        if (i_rst) begin
            o_result <= 10'h155;
        end else if (i_conv_start) begin
            // dummy pass has no channel connected, so only the offset shows
            o_result <= i_cal_mode ? CAL_OFF : i_level;
        end else if (!i_converting && !conv_q_ff) begin
            // outside a conversion the value is meaningless: keep it moving
            o_result <= ~o_result;
        end
    end
endmodule

// [adcsq_top_tb.sv]
`timescale 1ns/1ns
`include "adcsq_regs.svh"
module adcsq_top_tb;
    import adcsq_pkg::*;
    localparam logic [9:0] CAL_OFF = 10'h025;
    localparam int RC_HALF = 400;
    logic clk = 1'b0;
    logic ce = 1'b1;
    logic srst = 1'b1;
    logic rc_clk = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic trig = 1'b0;
    logic [12:0] pins = 13'h0;
    logic [9:0] lvl = 10'h0;
    adcsq_res_t core_res;
    logic [31:0] hrdata;
    logic [31:0] rdat;
    logic [15:0] last = 16'h0;
    logic hready, hresp, sample, converting, conv_start, cal_mode, timer_clr, done_flag;
    logic [3:0] channel;
    logic [31:0] seed = 32'd52010;
    int error_cnt = 0;
    int compares = 0;
    int n;
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #37;
        forever #(RC_HALF) rc_clk = ~rc_clk;
    end
    adcsq_top adcsq_top_inst (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hready),
        .I_RC_CLK(rc_clk), .I_SPECIAL_TRIG(trig), .I_CORE_RESULT(core_res), .I_PORT_PIN(pins),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_SAMPLE(sample),
        .O_CONVERTING(converting), .O_CONV_START(conv_start), .O_CAL_MODE(cal_mode),
        .O_CHANNEL(channel), .O_TIMER_CLR(timer_clr), .O_DONE_FLAG(done_flag));
    adcsq_core_model #(.CAL_OFF(CAL_OFF)) adcsq_core_model_inst (.i_clk(clk), .i_rst(srst),
        .i_conv_start(conv_start), .i_converting(converting), .i_cal_mode(cal_mode), .i_level(lvl),
        .o_result(core_res));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int acq_tads(input logic [2:0] c);
        int t[8];
        t = '{0, 2, 4, 6, 8, 12, 16, 20};
        return t[c];
    endfunction
    function automatic int div_of(input logic [2:0] c);
        if (c[1:0] == 2'b11) return 2 * RC_HALF / 100;
        return 2 << (c[2] + 2 * c[0] + 4 * c[1]);
    endfunction
    function automatic logic [15:0] expect_res(input logic [9:0] v, input logic rj);
        logic [9:0] r;
        r = (v > CAL_OFF) ? v - CAL_OFF : 10'h0;
        return rj ? {6'h0, r} : {r, 6'h0};
    endfunction
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        ahb(1'b0, a, xorshift());
    endtask
    task automatic cmp_res();
        rd(`ADCSQ_OFF_RESH);
        chk(rdat === {24'h0, last[15:8]}, "result high byte");
        rd(`ADCSQ_OFF_RESL);
        chk(rdat === {24'h0, last[7:0]}, "result low byte");
    endtask
    task automatic wait_start();
        n = 0;
        while (conv_start !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pulse();
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        #1;
    endtask
    task automatic run_conv(input logic [2:0] acq, input logic [2:0] cs, input logic rj, input logic cal);
        int d;
        int e;
        int lo;
        logic [3:0] ch;
        d = div_of(cs);
        e = acq_tads(acq) * d + ((acq == 3'd0 || cs[1:0] == 2'b11) ? 4 : 0);
        // the first rc bit period starts part way through
        if (cs[1:0] == 2'b11 && acq != 3'd0) e = e - d;
        lo = (acq == 3'd0 && cs[1:0] == 2'b11) ? 10 * d + 1 : 11 * d - 1;
        ch = 4'(xorshift());
        lvl <= 10'(xorshift());
        wr(`ADCSQ_OFF_CTRL2, {24'h0, rj, 1'b0, acq, cs});
        wr(`ADCSQ_OFF_STAT, 32'h1);
        tick(1);
        chk(done_flag === 1'b0, "done flag not cleared");
        if (acq == 3'd0) tick(30);
        wr(`ADCSQ_OFF_CTRL0, {24'h0, cal, 1'b0, ch, 2'b11});
        wait_start();
        chk(channel === ch, "channel select");
        if (!cal) chk(n >= e - 1 && n <= e + d + 3, "start to conversion");
        chk(cal_mode === cal, "calibration pass");
        n = 0;
        while (converting === 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        chk(n >= lo && n <= 11 * d + 1, "conversion length");
        if (!cal) chk(done_flag === 1'b1, "done flag");
        n = 0;
        while (sample !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 2 * d - 1 && n <= 2 * d + 3, "recovery wait");
        rd(`ADCSQ_OFF_CTRL0);
        chk(rdat[1] === 1'b0, "start flag stayed set");
        if (!cal) last = expect_res(lvl, rj);
        cmp_res();
        $display("conversion acq %0d clk %0d cal %0d finished", acq, cs, cal);
    endtask
    task automatic wrap_up();
        $display("checks %0d failed %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [2:0] divs[6];
        logic [12:0] m;
        divs = '{3'd0, 3'd4, 3'd1, 3'd5, 3'd2, 3'd6};
        tick(2);
        srst <= 1'b0;
        wr(`ADCSQ_OFF_CTRL0, 32'h1);
        run_conv(3'd2, 3'd0, 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) run_conv(3'(i), divs[i % 6], xorshift() & 1, 1'b0);
        run_conv(3'd0, 3'd3, 1'b1, 1'b0);
        run_conv(3'd2, 3'd7, 1'b0, 1'b0);
        wr(`ADCSQ_OFF_CTRL2, 32'h0);
        wr(`ADCSQ_OFF_STAT, 32'h1);
        tick(30);
        wr(`ADCSQ_OFF_CTRL0, 32'h17);
        wait_start();
        rd(`ADCSQ_OFF_CTRL0);
        chk(rdat[1] === 1'b1, "start flag low while busy");
        rd(`ADCSQ_OFF_STAT);
        chk(rdat[0] === 1'b0, "done shown mid conversion");
        wr(`ADCSQ_OFF_CTRL0, 32'h15);
        tick(2);
        chk(converting === 1'b0, "abort ignored");
        tick(20);
        chk(done_flag === 1'b0 && sample === 1'b1, "abort recovery");
        cmp_res();
        $display("abort test finished");
        for (int i = 0; i < 4; i++) begin
            m = 13'(xorshift());
            pins <= 13'(xorshift());
            wr(`ADCSQ_OFF_AMASK, {19'h0, m});
            tick(3);
            rd(`ADCSQ_OFF_PORT);
            chk(rdat === {19'h0, pins & ~m}, "port read");
        end
        wr(8'h24, 32'hffff);
        rd(8'h24);
        chk(rdat === 32'h0, "unmapped offset");
        $display("port test finished");
        wr(`ADCSQ_OFF_CTRL0, 32'h0);
        wr(`ADCSQ_OFF_CMODE, 32'ha);
        pulse();
        chk(timer_clr === 1'b0, "timer cleared in wrong mode");
        wr(`ADCSQ_OFF_CMODE, 32'hb);
        pulse();
        chk(timer_clr === 1'b1, "timer not cleared while off");
        tick(40);
        chk(converting === 1'b0, "trigger started while off");
        wr(`ADCSQ_OFF_CTRL0, 32'h1);
        pulse();
        chk(timer_clr === 1'b1, "timer not cleared");
        wait_start();
        chk(n < 100, "trigger did not start");
        ce <= 1'b0;
        tick(30);
        chk(converting === 1'b1 && done_flag === 1'b0, "clock enable did not freeze");
        ce <= 1'b1;
        tick(40);
        $display("trigger test finished");
        wr(`ADCSQ_OFF_STAT, 32'h1);
        wr(`ADCSQ_OFF_CTRL2, 32'h3e);
        wr(`ADCSQ_OFF_CTRL0, 32'h17);
        tick(20);
        wr(`ADCSQ_OFF_CTRL0, 32'h0);
        tick(1400);
        chk(converting === 1'b0 && done_flag === 1'b0, "disable did not abort");
        rd(`ADCSQ_OFF_CTRL0);
        chk(rdat === 32'h0, "start flag after disable");
        wr(`ADCSQ_OFF_CTRL0, 32'h1);
        wr(`ADCSQ_OFF_CTRL0, 32'h3);
        tick(5);
        srst <= 1'b1;
        tick(1);
        srst <= 1'b0;
        #1;
        chk(converting === 1'b0 && done_flag === 1'b0 && hready === 1'b1 && hresp === 1'b0, "reset state");
        rd(`ADCSQ_OFF_CTRL0);
        chk(rdat === 32'h0, "control zero after reset");
        rd(`ADCSQ_OFF_CTRL2);
        chk(rdat === 32'h0, "acquisition field reset");
        rd(`ADCSQ_OFF_AMASK);
        chk(rdat === {19'h0, `ADCSQ_RST_AMASK}, "mask reset");
        $display("reset test finished");
        wrap_up();
    end
endmodule
